// File: loop_setup_regs.svh
// Purpose: offsets, field positions, reset values and counts of the loop setup decoder
// Assumes: 48-bit instruction words, APB register access with 32-bit data
// Notes:   definitions only
`ifndef LOOP_SETUP_REGS_SVH
`define LOOP_SETUP_REGS_SVH

// instruction word fields
`define OPC_TOP_HI        47
`define OPC_TOP_LO        45
`define OPC_TOP_VAL       3'h0
`define OPC_GRP_HI        44
`define OPC_GRP_LO        41
`define OPC_GRP_CNT_LOOP  4'h6
`define OPC_GRP_CND_LOOP  4'h7
`define OPC_DIR_HI        44
`define OPC_DIR_LO        42
`define OPC_DIR_MOVE      3'h4
`define OPC_CNT_SEL_BIT   40
`define OPC_IMM_HI        39
`define OPC_IMM_LO        24
`define OPC_UREG_HI       38
`define OPC_UREG_LO       32
`define OPC_TERM_HI       37
`define OPC_TERM_LO       33
`define OPC_MEM_G_BIT     41
`define OPC_MEM_D_BIT     40
`define OPC_MEM_L_BIT     39
`define OPC_ADDR_HI       31
`define OPC_ADDR_LO       0
`define OPC_OFS_HI        23
`define OPC_OFS_LO        0

// exit condition code stored for counter loops
`define COND_COUNT_EXPIRED 5'h1f
// depth of the combined loop address and counter stack
`define LOOP_DEPTH        6
`define LOOP_PTR_W        3

// register byte offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_COUNT         12'h008
`define REG_END_ADDR      12'h00c
`define REG_MEM_ADDR      12'h010
// control fields
`define CTRL_DUAL_BIT     0
`define CTRL_ABS_BIT      1
`define CTRL_RESET        32'h0000_0000
`endif

// File: loop_setup_pkg.sv
// Purpose: types shared by the loop setup decoder and its helpers
// Assumes: widths fixed at the documented values
// Notes:   constants live in loop_setup_regs.svh
package loop_setup_pkg;
   typedef logic [47:0] instr_t;
   typedef logic [23:0] paddr_t;

   // one entry of the loop address and counter stack
   typedef struct packed {
      paddr_t      end_addr;
      logic [4:0]  cond;
      logic        is_counter;
      logic [15:0] count;
   } loop_entry_s;

   // direct-addressed move request towards the memory port
   typedef struct packed {
      logic [31:0] addr_x;
      logic [31:0] addr_y;
      logic        write;
      logic        prog;
      logic        long_word;
      logic        dual;
      logic [6:0]  ureg;
   } mem_req_s;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_UREG_WAIT
   } dec_state_e;
endpackage

// File: end_addr_calc.sv
// Purpose: turn the 24-bit end field into an absolute loop end address
// Assumes: relative field is two's complement from the setup instruction address
// Notes:   pure combinational adder, wraps modulo 2^24
`timescale 1ns/100ps
module end_addr_calc (
   input  wire loop_setup_pkg::paddr_t setup_pc,    // address of the setup instruction
   input  wire logic [23:0]            end_field,   // end field of the word
   input  wire logic                   absolute,    // field already holds the address
   output loop_setup_pkg::paddr_t      end_addr     // absolute loop end
);
   import loop_setup_pkg::*;

   // sign-extended offset add
   // both forms are 24 bits wide, so the sum wraps like the fetch counter does
   assign end_addr = absolute ? end_field : paddr_t'(setup_pc + end_field);
endmodule

// File: exit_cond_eval.sv
// Purpose: decide whether the innermost loop leaves at its end address
// Assumes: lane condition results belong to the stored exit condition
// Notes:   combinational
`timescale 1ns/100ps
module exit_cond_eval (
   input  wire loop_setup_pkg::loop_entry_s top,     // innermost loop entry
   input  wire logic                        dual,    // dual_lane_mode
   input  wire logic                        cond_x,  // condition result in lane_x
   input  wire logic                        cond_y,  // condition result in lane_y
   output logic                             leave    // loop ends here
);
   import loop_setup_pkg::*;

   always_comb begin
      if (top.is_counter) begin
         leave = (top.count <= 16'h0001);
      end else if (dual) begin
         leave = cond_x & cond_y;
      end else begin
         leave = cond_x;
      end
   end
endmodule

// File: loop_setup_decoder.sv
// Purpose: decode loop setup and direct move words, keep the loop stack
// Assumes: sequencer logic on the same clock; APB master for control
// Notes:   program-counter stack lives in the sequencer, driven by pushes
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "loop_setup_regs.svh"
module loop_setup_decoder (
   input  wire logic                        clock,         // core clock, 20 MHz
   input  wire logic                        rst,           // synchronous reset, high
   // APB slave
   input  wire logic                        psel,          // slave select
   input  wire logic                        penable,       // access phase
   input  wire logic                        pwrite,        // write when high
   input  wire logic [11:0]                 paddr,         // byte address
   input  wire logic [31:0]                 pwdata,        // write data
   output logic [31:0]                      prdata,        // read data
   output logic                             pready,        // always ready
   output logic                             pslverr,       // unmapped address
   // instruction stream
   input  wire logic                        instr_valid,   // word offered
   output logic                             instr_ready,   // word taken
   input  wire loop_setup_pkg::instr_t      instr,         // instruction word
   input  wire loop_setup_pkg::paddr_t      instr_pc,      // its address
   // universal register read port
   output logic [6:0]                       ureg_sel,      // register number
   input  wire logic [31:0]                 ureg_data,     // value, next cycle
   // program-counter stack
   output logic                             pc_push,       // push pulse
   output loop_setup_pkg::paddr_t           pc_push_addr,  // loop start address
   output logic                             pc_pop,        // pop pulse on exit
   // fetch watch and lane conditions
   input  wire logic                        fetch_valid,   // fetch_pc is valid
   input  wire loop_setup_pkg::paddr_t      fetch_pc,      // address fetched
   input  wire logic                        cond_x,        // exit test, lane_x
   input  wire logic                        cond_y,        // exit test, lane_y
   output logic [4:0]                       top_cond,      // condition to test
   output logic                             loop_repeat,   // jump to start pulse
   output logic                             loop_exit,     // fall through pulse
   output logic [15:0]                      current_loop_count, // innermost count
   // direct move
   output logic                             mem_valid,     // request pulse
   output loop_setup_pkg::mem_req_s         mem_req        // request fields
);
   import loop_setup_pkg::*;

   dec_state_e          state_r;
   loop_entry_s         stack_r [`LOOP_DEPTH];
   logic [`LOOP_PTR_W-1:0] sp_r;            // number of live entries
   logic [31:0]         ctrl_r;
   logic                overflow_r;
   logic [15:0]         loop_count_load_reg;
   paddr_t              pend_pc_r;
   paddr_t              last_end_r;
   logic [31:0]         last_mem_r;
   instr_t              held_r;

   logic                dual_lane_mode;
   logic                end_abs;
   logic                top_ok;
   logic                is_cnt_loop;
   logic                is_cnd_loop;
   logic                is_move;
   logic                take;
   logic                push_cnt;
   logic                push_cnd;
   logic [15:0]         push_count;
   paddr_t              setup_end;
   paddr_t              sel_pc;
   logic [23:0]         sel_field;
   loop_entry_s         top;
   logic                leave;
   logic                end_hit;
   logic                do_push;
   logic                do_pop;
   loop_entry_s         new_entry;
   logic [31:0]         mem_addr;

   assign dual_lane_mode = ctrl_r[`CTRL_DUAL_BIT];
   assign end_abs        = ctrl_r[`CTRL_ABS_BIT];

   // opcode recognition on the offered word
   // condition loop pattern
   assign is_cnd_loop = (instr[`OPC_TOP_HI:`OPC_TOP_LO] == `OPC_TOP_VAL)
                      && (instr[`OPC_GRP_HI:`OPC_GRP_LO] == `OPC_GRP_CND_LOOP);
   assign is_cnt_loop = (instr[`OPC_TOP_HI:`OPC_TOP_LO] == `OPC_TOP_VAL)
                      && (instr[`OPC_GRP_HI:`OPC_GRP_LO] == `OPC_GRP_CNT_LOOP);
   assign is_move     = (instr[`OPC_TOP_HI:`OPC_TOP_LO] == `OPC_TOP_VAL)
                      && (instr[`OPC_DIR_HI:`OPC_DIR_LO] == `OPC_DIR_MOVE);
   assign instr_ready = (state_r == ST_IDLE);
   assign take        = instr_valid && instr_ready;

   // register source is read in the cycle the word is taken
   assign ureg_sel = instr[`OPC_UREG_HI:`OPC_UREG_LO];

   // decoder state: the register form waits one cycle for its value
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (take && is_cnt_loop && instr[`OPC_CNT_SEL_BIT]) begin
                  state_r <= ST_UREG_WAIT;
               end
            end
            ST_UREG_WAIT: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // hold the word and its address while the register value arrives
   always_ff @(posedge clock) begin
      if (rst) begin
         held_r    <= 48'h0000_0000_0000;
         pend_pc_r <= 24'h00_0000;
      end else if (take) begin
         held_r    <= instr;
         pend_pc_r <= instr_pc;
      end
   end

   // one adder serves both the immediate and the waiting register form
   assign sel_pc    = (state_r == ST_UREG_WAIT) ? pend_pc_r : instr_pc;
   assign sel_field = (state_r == ST_UREG_WAIT) ? held_r[`OPC_OFS_HI:`OPC_OFS_LO]
                                                : instr[`OPC_OFS_HI:`OPC_OFS_LO];

   end_addr_calc u_end (
      .setup_pc  (sel_pc),
      .end_field (sel_field),
      .absolute  (end_abs),
      .end_addr  (setup_end)
   );

   // push decisions and the count to load
   always_comb begin
      push_cnt   = 1'b0;
      push_cnd   = 1'b0;
      push_count = 16'h0000;
      if (state_r == ST_UREG_WAIT) begin
         push_cnt   = 1'b1;
         push_count = ureg_data[15:0];
      end else if (take && is_cnt_loop && !instr[`OPC_CNT_SEL_BIT]) begin
         push_cnt   = 1'b1;
         push_count = instr[`OPC_IMM_HI:`OPC_IMM_LO];
      end else if (take && is_cnd_loop) begin
         push_cnd   = 1'b1;
      end
   end
   assign do_push = push_cnt | push_cnd;

   // entry built for the loop stack
   always_comb begin
      new_entry          = '0;
      new_entry.end_addr = setup_end;
      new_entry.count    = push_count;
      if (push_cnt) begin
         // count expiry is the exit test
         new_entry.cond       = `COND_COUNT_EXPIRED;
         new_entry.is_counter = 1'b1;
      end else begin
         new_entry.cond       = instr[`OPC_TERM_HI:`OPC_TERM_LO];
         new_entry.is_counter = 1'b0;
      end
   end

   // software-visible copy of the last loaded count
   always_ff @(posedge clock) begin
      if (rst) begin
         loop_count_load_reg <= 16'h0000;
      end else if (push_cnt) begin
         loop_count_load_reg <= push_count;
      end
   end

   // body start goes to pc stack
   always_ff @(posedge clock) begin
      if (rst) begin
         pc_push      <= 1'b0;
         pc_push_addr <= 24'h00_0000;
      end else begin
         pc_push <= do_push;
         if (do_push) begin
            pc_push_addr <= paddr_t'(sel_pc + 24'h00_0001);
         end
      end
   end

   // innermost entry and end detection
   assign top_ok = (sp_r != 3'h0);
   always_comb begin
      top = '0;
      if (top_ok) begin
         top = stack_r[sp_r - 3'h1];
      end
   end
   assign end_hit  = top_ok && fetch_valid && (fetch_pc == top.end_addr);
   assign top_cond = top.cond;
   assign current_loop_count = top.count;

   exit_cond_eval u_exit (
      .top    (top),
      .dual   (dual_lane_mode),
      .cond_x (cond_x),
      .cond_y (cond_y),
      .leave  (leave)
   );
   assign do_pop = end_hit && leave;

   // stack pointer: a setup and an exit in one cycle replace the top
   always_ff @(posedge clock) begin
      if (rst) begin
         sp_r <= 3'h0;
      end else if (do_push && !do_pop && sp_r != 3'(`LOOP_DEPTH)) begin
         sp_r <= sp_r + 3'h1;
      end else if (do_pop && !do_push) begin
         sp_r <= sp_r - 3'h1;
      end
   end

   // stack storage, one slot per entry
   genvar gi;
   generate
      for (gi = 0; gi < `LOOP_DEPTH; gi++) begin : g_slot
         always_ff @(posedge clock) begin
            if (rst) begin
               stack_r[gi] <= '0;
            end else if (do_push && !do_pop && 3'(gi) == sp_r) begin
               stack_r[gi] <= new_entry;
            end else if (do_push && do_pop && 3'(gi) == sp_r - 3'h1) begin
               stack_r[gi] <= new_entry;
            end else if (end_hit && !leave && top.is_counter
                         && 3'(gi) == sp_r - 3'h1) begin
               stack_r[gi].count <= top.count - 16'h0001;
            end
         end
      end
   endgenerate

   // sticky overflow: a push onto a full stack is dropped
   always_ff @(posedge clock) begin
      if (rst) begin
         overflow_r <= 1'b0;
      end else if (do_push && !do_pop && sp_r == 3'(`LOOP_DEPTH)) begin
         overflow_r <= 1'b1;
      end else if (psel && penable && pwrite && paddr == `REG_STATUS && pwdata[0]) begin
         overflow_r <= 1'b0;
      end
   end

   // loop end answers to the sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         loop_repeat <= 1'b0;
         loop_exit   <= 1'b0;
         pc_pop      <= 1'b0;
      end else begin
         loop_repeat <= end_hit && !leave;
         loop_exit   <= do_pop;
         pc_pop      <= do_pop;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         last_end_r <= 24'h00_0000;
      end else if (do_push) begin
         last_end_r <= setup_end;
      end
   end

   assign mem_addr = instr[`OPC_ADDR_HI:`OPC_ADDR_LO];

   // direct-addressed move request
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_valid  <= 1'b0;
         mem_req    <= '0;
         last_mem_r <= 32'h0000_0000;
      end else begin
         mem_valid <= take && is_move;
         if (take && is_move) begin
            mem_req.addr_x    <= mem_addr;
            mem_req.addr_y    <= dual_lane_mode ? mem_addr + 32'h0000_0001 : mem_addr;
            mem_req.write     <= instr[`OPC_MEM_D_BIT];
            mem_req.prog      <= instr[`OPC_MEM_G_BIT];
            mem_req.long_word <= instr[`OPC_MEM_L_BIT];
            mem_req.dual      <= dual_lane_mode;
            mem_req.ureg      <= instr[`OPC_UREG_HI:`OPC_UREG_LO];
            last_mem_r        <= mem_addr;
         end
      end
   end

   // APB: zero wait states, errors for unmapped addresses
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(paddr == `REG_CTRL || paddr == `REG_STATUS
                    || paddr == `REG_COUNT || paddr == `REG_END_ADDR
                    || paddr == `REG_MEM_ADDR);

   // control register steers mode and end form
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_r <= `CTRL_RESET;
      end else if (psel && penable && pwrite && paddr == `REG_CTRL) begin
         ctrl_r <= {30'h0000_0000, pwdata[`CTRL_ABS_BIT], pwdata[`CTRL_DUAL_BIT]};
      end
   end

   // read mux; data only looked at in the access phase
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         `REG_CTRL:     prdata = ctrl_r;
         `REG_STATUS:   prdata = {24'h00_0000, 1'b0, sp_r, 2'b00, top_ok, overflow_r};
         `REG_COUNT:    prdata = {loop_count_load_reg, top.count};
         `REG_END_ADDR: prdata = {8'h00, last_end_r};
         `REG_MEM_ADDR: prdata = last_mem_r;
         default:       prdata = 32'h0000_0000;
      endcase
   end

   // checks next to the logic above
   property p_imm_count;
      @(posedge clock) disable iff (rst)
      (take && is_cnt_loop && !instr[`OPC_CNT_SEL_BIT])
         |=> loop_count_load_reg == $past(instr[`OPC_IMM_HI:`OPC_IMM_LO]);
   endproperty
   a_imm_count: assert property (p_imm_count) else $error("immediate count not loaded");

   property p_ureg_count;
      @(posedge clock) disable iff (rst)
      (take && is_cnt_loop && instr[`OPC_CNT_SEL_BIT])
         |=> ##1 loop_count_load_reg == $past(ureg_data[15:0]);
   endproperty
   a_ureg_count: assert property (p_ureg_count) else $error("register count not loaded");

   property p_pc_push;
      @(posedge clock) disable iff (rst)
      (take && is_cnd_loop) |=> pc_push && pc_push_addr == $past(instr_pc) + 24'h00_0001;
   endproperty
   a_pc_push: assert property (p_pc_push) else $error("loop start not pushed");

   property p_end_rel;
      @(posedge clock) disable iff (rst)
      (take && is_cnd_loop && !end_abs)
         |=> last_end_r == paddr_t'($past(instr_pc) + $past(instr[23:0]));
   endproperty
   a_end_rel: assert property (p_end_rel) else $error("end address wrong");

   property p_dual_exit;
      @(posedge clock) disable iff (rst)
      (end_hit && !top.is_counter && dual_lane_mode && !(cond_x && cond_y))
         |=> !loop_exit && loop_repeat;
   endproperty
   a_dual_exit: assert property (p_dual_exit) else $error("dual lane exit on one lane");

   property p_single_exit;
      @(posedge clock) disable iff (rst)
      (end_hit && !top.is_counter && !dual_lane_mode && cond_x) |=> loop_exit && pc_pop;
   endproperty
   a_single_exit: assert property (p_single_exit) else $error("single lane exit missed");

   property p_count_dec;
      @(posedge clock) disable iff (rst)
      (end_hit && top.is_counter && top.count > 16'h0001 && !do_push)
         |=> current_loop_count == $past(top.count) - 16'h0001 && !loop_exit;
   endproperty
   a_count_dec: assert property (p_count_dec) else $error("count not decremented");

   property p_lane_y;
      @(posedge clock) disable iff (rst)
      (take && is_move && dual_lane_mode)
         |=> mem_valid && mem_req.addr_y == $past(instr[31:0]) + 32'h0000_0001;
   endproperty
   a_lane_y: assert property (p_lane_y) else $error("lane y address wrong");

   property p_long_word;
      @(posedge clock) disable iff (rst)
      (take && is_move) |=> mem_req.long_word == $past(instr[`OPC_MEM_L_BIT])
                            && mem_req.addr_x == $past(instr[31:0]);
   endproperty
   a_long_word: assert property (p_long_word) else $error("move fields wrong");
endmodule

// File: ureg_file_model.sv
// Purpose: universal register file model that feeds the counter load
// Assumes: data is wanted the cycle after the select is shown
// Notes:   registered read, so a select change never shows through early
`timescale 1ns/100ps
module ureg_file_model (
   input  wire logic        clock,     // core clock
   input  wire logic [6:0]  ureg_sel,  // register number
   output logic [31:0]      ureg_data  // value, one cycle late
);
   always_ff @(posedge clock) begin
      ureg_data <= {16'hffff, 9'h000, ureg_sel};  // upper half must be ignored
   end
endmodule

// File: loop_setup_decoder_tb.sv
// Purpose: self-checking bench of the loop setup decoder
// Assumes: zero-wait register bus, partner register file on the read port
// Notes:   expected values come from the field layout only
`timescale 1ns/100ps
`include "loop_setup_regs.svh"
module loop_setup_decoder_tb;
   import loop_setup_pkg::*;
   logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, ureg_data, q;
   logic        pready, pslverr, instr_ready, pc_push, pc_pop, e;
   logic        instr_valid = 0, fetch_valid = 0, cond_x = 0, cond_y = 0;
   logic        loop_repeat, loop_exit, mem_valid;
   instr_t      instr = 0;
   paddr_t      instr_pc = 0, fetch_pc = 0, pc_push_addr;
   logic [6:0]  ureg_sel;
   logic [4:0]  top_cond;
   logic [15:0] current_loop_count;
   mem_req_s    mem_req;
   int          fail_count = 0, comparisons = 0;

   always #25 clock = ~clock;

   loop_setup_decoder i_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .instr_valid, .instr_ready, .instr, .instr_pc,
      .ureg_sel, .ureg_data, .pc_push, .pc_push_addr, .pc_pop, .fetch_valid,
      .fetch_pc, .cond_x, .cond_y, .top_cond, .loop_repeat, .loop_exit,
      .current_loop_count, .mem_valid, .mem_req);
   ureg_file_model i_ureg (.clock, .ureg_sel, .ureg_data);

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [47:0] s, input logic [47:0] x);
      comparisons++;
      if (s !== x) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask

   // one bus transfer; holds the request until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      for (n = 0; n < 16; n++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin fail_count++; print_verdict; end
      q = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
      @(posedge clock);
   endtask

   // offer one word, then wait the stated answer latency
   task automatic send(input instr_t w, input paddr_t pc, input int lat);
      int n;
      instr_valid <= 1; instr <= w; instr_pc <= pc;
      for (n = 0; n < 16; n++) begin
         @(posedge clock);
         if (instr_ready === 1'b1) break;
      end
      if (n == 16) begin fail_count++; print_verdict; end
      instr_valid <= 0;
      repeat (lat) @(posedge clock);
   endtask

   // fetch reaches the end address with given lane results
   task automatic hit(input paddr_t a, input logic cx, cy, ex);
      fetch_valid <= 1; fetch_pc <= a; cond_x <= cx; cond_y <= cy;
      @(posedge clock);
      fetch_valid <= 0;
      @(posedge clock);
      chk(loop_exit, ex);
      chk(pc_pop, ex);
      chk(loop_repeat, !ex);
   endtask

   task automatic t_apb;
      apb(0, `REG_CTRL, 0); chk(q, `CTRL_RESET);
      apb(1, `REG_CTRL, 3); apb(0, `REG_CTRL, 0); chk(q, 3);
      apb(0, 12'h020, 0); chk(e, 1); chk(q, 0);
      apb(1, `REG_CTRL, 0);
      $display("test apb done");
   endtask

   task automatic t_counter;
      int i;
      send({3'h0, 4'h6, 1'b0, 16'h0002, 24'h00_0010}, 24'h00_0100, 1);
      chk(pc_push, 1);
      chk(pc_push_addr, 24'h00_0101);
      chk(current_loop_count, 2);
      chk(top_cond, `COND_COUNT_EXPIRED);
      hit(24'h00_0110, 0, 0, 0);
      chk(current_loop_count, 1);
      hit(24'h00_0110, 0, 0, 1);
      send({3'h0, 4'h6, 2'b10, 7'h15, 8'h00, 24'h00_0008}, 24'h00_0200, 2);
      chk(pc_push, 1);
      chk(current_loop_count, 16'h0015);
      for (i = 0; i < 20; i++) hit(24'h00_0208, 0, 0, 0);
      hit(24'h00_0208, 0, 0, 1);
      $display("test counter done");
   endtask

   task automatic t_cond;
      apb(1, `REG_CTRL, 1);
      send({3'h0, 4'h7, 3'h0, 5'h0a, 9'h000, 24'hff_fffc}, 24'h00_0300, 1);
      chk(pc_push, 1);
      chk(pc_push_addr, 24'h00_0301);
      chk(top_cond, 5'h0a);
      hit(24'h00_02fc, 1, 0, 0);
      hit(24'h00_02fc, 1, 1, 1);
      apb(0, `REG_END_ADDR, 0); chk(q, 32'h0000_02fc);
      apb(1, `REG_CTRL, 2);
      send({3'h0, 4'h7, 3'h0, 5'h03, 9'h000, 24'h00_0400}, 24'h00_0500, 1);
      hit(24'h00_0400, 0, 1, 0);
      hit(24'h00_0400, 1, 0, 1);
      $display("test condition done");
   endtask

   task automatic t_move;
      apb(1, `REG_CTRL, 1);
      send({3'h0, 3'h4, 3'h7, 7'h22, 32'h1234_5678}, 24'h00_0600, 1);
      chk(mem_valid, 1);
      chk(mem_req.addr_x, 32'h1234_5678);
      chk(mem_req.addr_y, 32'h1234_5679);
      chk({mem_req.long_word, mem_req.dual, mem_req.ureg}, {2'h3, 7'h22});
      chk({mem_req.write, mem_req.prog}, 2'h3);
      $display("test move done");
   endtask

   // fill the stack past its depth, then read and clear the sticky overflow
   task automatic t_stack;
      int i;
      apb(1, `REG_CTRL, 0);
      for (i = 0; i < 7; i++)
         send({3'h0, 4'h7, 3'h0, 5'h01, 9'h000, 24'h00_0040}, 24'h00_0800, 1);
      apb(0, `REG_STATUS, 0); chk(q, 32'h0000_0063);
      apb(1, `REG_STATUS, 1);
      apb(0, `REG_STATUS, 0); chk(q, 32'h0000_0062);
      apb(0, `REG_COUNT, 0); chk(q, 32'h0015_0000);
      $display("test stack done");
   endtask

   initial begin
      repeat (4) @(posedge clock);
      rst <= 0;
      repeat (2) @(posedge clock);
      t_apb;
      t_counter;
      t_cond;
      t_move;
      t_stack;
      print_verdict;
   end
endmodule
